// File: pkg/led_boost_pkg.sv
// Purpose: shared constants, state types and pin bundles for the boost LED controller
// Assumes: 100 MHz mclk, analog comparators deliver logic levels on the sense pins
// Notes: times are kept in ns and turned into cycle counts here
//
// Summary of operation
// - switch-node overvoltage eight cycles: switch off, shutdown
// - overvoltage shutdown holds until enable input held low beyond 2.5ms
// - enable low beyond 2.5ms enters shutdown
// - 200mV reference chopped in step with dimming
// - steady high input regulates full 200mV
// - chopped reference low-pass filtered before use
// - low supply forces shutdown, switch held off
// - thermal alarm turns off, auto release
// - supply good, input high: start soft-start
// - held disabled: no switching, low power
// - amplifier target ramps slowly after enable
// - 1.2MHz cycles, switch off at current threshold
package led_boost_pkg;
    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_HZ = 100_000_000; // mclk rate
    localparam int CLK_PERIOD_NS = 10; // mclk period
    localparam int SW_FREQ_HZ = 1_200_000; // nominal switching rate
    localparam int SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ; // floor, 83 cycles
    localparam int SW_CNT_W = 7; // holds SW_PERIOD_CYC - 1
    localparam int OVP_CYCLES = 8; // consecutive overvoltage cycles to trip
    localparam int OVP_CNT_W = 4; // holds OVP_CYCLES
    localparam int LOW_SD_NS = 2_500_000; // low time before shutdown
    // least time: round up
    localparam int LOW_SD_CYC = (LOW_SD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_CNT_W = 18; // holds LOW_SD_CYC
    localparam int SOFT_STEP_NS = 5_000; // soft-start step interval
    localparam int SOFT_STEP_CYC = SOFT_STEP_NS / CLK_PERIOD_NS;
    localparam int SOFT_CNT_W = 10; // holds SOFT_STEP_CYC - 1

    // ==========================================================
    // reference and filter
    // ==========================================================
    localparam int REF_W = 8; // reference code width, one lsb = 1 mV
    localparam logic [7:0] REF_FULL_MV = 8'hC8; // 200 mV
    localparam int LPF_TAU_NS = 100_000; // filter time constant
    localparam int LPF_TAU_CYC = LPF_TAU_NS / CLK_PERIOD_NS;
    // shift gives a power-of-two time constant just below the target
    localparam int LPF_SHIFT = 13;
    localparam int ACC_W = REF_W + LPF_SHIFT; // filter accumulator

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00, // shutdown, no switching
        ST_SOFT = 2'b01, // soft-start ramp
        ST_RUN  = 2'b10, // regulating
        ST_OVP  = 2'b11  // latched overvoltage shutdown
    } mode_t;

    // comparator and pin levels, all asynchronous to mclk
    typedef struct packed {
        logic dim; // dimming/enable control pin
        logic supply_ok; // supply above lockout threshold (hysteresis analog)
        logic hot; // thermal alarm (hysteresis analog)
        logic ovp; // switch_node above switch_overvoltage_threshold
        logic ilim; // inductor current at amplifier threshold
    } sense_t;

    typedef struct packed {
        sense_t sync1; // first synchroniser stage
        sense_t sync2; // second synchroniser stage
        mode_t mode;
        logic [LOW_CNT_W-1:0] low_cnt;
        logic [SW_CNT_W-1:0] sw_cnt;
        logic ovp_seen; // overvoltage seen in current switching cycle
        logic [OVP_CNT_W-1:0] ovp_cnt;
        logic [SOFT_CNT_W-1:0] step_cnt;
        logic [REF_W-1:0] soft_level;
        logic [REF_W-1:0] target;
        logic sw_on;
        logic act;
        logic low_power;
        logic ref_gate;
        logic ovp_off;
    } ctrl_state_t;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
    } lpf_state_t;
endpackage : led_boost_pkg

// File: core/ref_lowpass.sv
// Purpose: first-order low-pass on the chopped reference
// Assumes: gate is a same-clock level
// Notes: output moves at most one code per cycle, so the target never steps while switching
`timescale 1ns/10ps
module ref_lowpass (
    input wire logic mclk,
    input wire logic reset,
    input wire logic gate,
    output logic [led_boost_pkg::REF_W-1:0] level
);
    // ==========================================================
    // state
    // ==========================================================
    led_boost_pkg::lpf_state_t r_reg; // accumulator register
    led_boost_pkg::lpf_state_t r_next;
    localparam int AW = led_boost_pkg::ACC_W;
    localparam int SH = led_boost_pkg::LPF_SHIFT;

    // chopped input: full reference or zero, acc += x - acc/2^SH
    always_comb begin
        logic [AW-1:0] x;
        x = AW'(0);
        if (gate) begin
            x = AW'(led_boost_pkg::REF_FULL_MV);
        end
        r_next = r_reg;
        r_next.acc = r_reg.acc + x - AW'(r_reg.acc[AW-1:SH]);
    end

    // register the whole state
    always_ff @(posedge mclk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign level = r_reg.acc[AW-1:SH];
endmodule : ref_lowpass

// File: core/led_boost_dim_protect_ctrl.sv
// Purpose: enable, dimming reference, soft-start and protection control of a boost LED driver
// Assumes: sense pins come from analog comparators, asynchronous to mclk
// Notes: reset stands in for the supply lockout power-on reset
`timescale 1ns/10ps
module led_boost_dim_protect_ctrl #(
    parameter int LOW_SD_CYC = led_boost_pkg::LOW_SD_CYC,
    // soft-start step interval; a bench may shorten it to keep runs short
    parameter int SOFT_STEP_CYC = led_boost_pkg::SOFT_STEP_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire led_boost_pkg::sense_t sense_pins,
    output logic power_switch_on,
    output logic switching_active,
    output logic low_power,
    output logic ref_gate,
    output logic [led_boost_pkg::REF_W-1:0] reg_target,
    output logic ovp_shutdown
);
    // ==========================================================
    // constants and state
    // ==========================================================
    localparam int LW = led_boost_pkg::LOW_CNT_W;
    localparam int SWW = led_boost_pkg::SW_CNT_W;
    localparam int OW = led_boost_pkg::OVP_CNT_W;
    localparam int STW = led_boost_pkg::SOFT_CNT_W;
    localparam int RW = led_boost_pkg::REF_W;
    localparam logic [LW-1:0] LOW_LAST = LW'(LOW_SD_CYC);
    localparam logic [SWW-1:0] SW_LAST = SWW'(led_boost_pkg::SW_PERIOD_CYC - 1);
    localparam logic [OW-1:0] OVP_LAST = OW'(led_boost_pkg::OVP_CYCLES - 1);
    localparam logic [STW-1:0] STEP_LAST = STW'(SOFT_STEP_CYC - 1);

    led_boost_pkg::ctrl_state_t r_reg; // all control state
    led_boost_pkg::ctrl_state_t r_next;
    logic [led_boost_pkg::REF_W-1:0] lpf_level; // filtered reference

    // smaller of two codes, used for the target
    function automatic logic [led_boost_pkg::REF_W-1:0] min_code(
        input logic [led_boost_pkg::REF_W-1:0] a,
        input logic [led_boost_pkg::REF_W-1:0] b
    );
        min_code = (a < b) ? a : b;
    endfunction : min_code

    // ==========================================================
    // reference filter
    // ==========================================================
    ref_lowpass u_lpf (
        .mclk(mclk),
        .reset(reset),
        .gate(r_reg.ref_gate),
        .level(lpf_level)
    );

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb begin
        led_boost_pkg::sense_t s;
        logic low_expired;
        logic cyc_end;
        logic seen_now;
        logic trip;
        logic run;
        s = r_reg.sync2;
        low_expired = 1'b0;
        cyc_end = 1'b0;
        seen_now = 1'b0;
        trip = 1'b0;
        run = 1'b0;
        r_next = r_reg;
        // synchronisers: stage one is read only by stage two
        r_next.sync1 = sense_pins;
        r_next.sync2 = r_reg.sync1;

        if (s.dim) begin
            r_next.low_cnt = '0;
        end else if (r_reg.low_cnt != LOW_LAST) begin
            r_next.low_cnt = r_reg.low_cnt + LW'(1);
        end
        low_expired = !s.dim && (r_reg.low_cnt == LOW_LAST);

        cyc_end = (r_reg.sw_cnt == SW_LAST);
        r_next.sw_cnt = cyc_end ? '0 : r_reg.sw_cnt + SWW'(1);

        // overvoltage sampled over each whole switching cycle
        seen_now = r_reg.ovp_seen | s.ovp;
        r_next.ovp_seen = cyc_end ? 1'b0 : seen_now;
        trip = cyc_end && seen_now && (r_reg.ovp_cnt == OVP_LAST);
        if (cyc_end) begin
            r_next.ovp_cnt = seen_now ? r_reg.ovp_cnt + OW'(1) : '0;
        end

        // mode machine
        unique case (r_reg.mode)
            led_boost_pkg::ST_OFF: begin
                if (s.dim && s.supply_ok && !s.hot) begin
                    r_next.mode = led_boost_pkg::ST_SOFT;
                end
            end
            led_boost_pkg::ST_SOFT, led_boost_pkg::ST_RUN: begin
                if (!s.supply_ok || s.hot || low_expired) begin
                    r_next.mode = led_boost_pkg::ST_OFF;
                end else if (trip) begin
                    r_next.mode = led_boost_pkg::ST_OVP;
                end else if (r_reg.soft_level == led_boost_pkg::REF_FULL_MV) begin
                    r_next.mode = led_boost_pkg::ST_RUN;
                end
            end
            led_boost_pkg::ST_OVP: begin
                if (low_expired) begin
                    r_next.mode = led_boost_pkg::ST_OFF;
                end
            end
        endcase
        run = (r_next.mode == led_boost_pkg::ST_SOFT) || (r_next.mode == led_boost_pkg::ST_RUN);

        if (!run) begin
            r_next.soft_level = '0;
            r_next.step_cnt = '0;
            r_next.ovp_cnt = '0;
        end else if (r_reg.soft_level != led_boost_pkg::REF_FULL_MV) begin
            r_next.step_cnt = (r_reg.step_cnt == STEP_LAST) ? '0 : r_reg.step_cnt + STW'(1);
            if (r_reg.step_cnt == STEP_LAST) begin
                r_next.soft_level = r_reg.soft_level + RW'(1);
            end
        end

        // on at cycle start, off at current threshold
        r_next.sw_on = run && !s.ilim && (cyc_end || r_reg.sw_on);
        r_next.ref_gate = run && s.dim;
        r_next.target = run ? min_code(lpf_level, r_reg.soft_level) : '0;
        r_next.act = run;
        r_next.low_power = !run;
        r_next.ovp_off = (r_next.mode == led_boost_pkg::ST_OVP);
    end

    // ==========================================================
    // state register
    // ==========================================================
    always_ff @(posedge mclk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.low_power <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign power_switch_on = r_reg.sw_on;
    assign switching_active = r_reg.act;
    assign low_power = r_reg.low_power;
    assign ref_gate = r_reg.ref_gate;
    assign reg_target = r_reg.target;
    assign ovp_shutdown = r_reg.ovp_off;

    // ==========================================================
    // checks
    // ==========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    logic ovp_trip_h; // helper: trip condition this cycle
    assign ovp_trip_h = (r_reg.sw_cnt == SW_LAST) && (r_reg.ovp_seen | r_reg.sync2.ovp)
        && (r_reg.ovp_cnt == OVP_LAST) && r_reg.act && r_reg.sync2.supply_ok
        && !r_reg.sync2.hot && (r_reg.sync2.dim || r_reg.low_cnt != LOW_LAST);

    ovp_trip_off_a: assert property (ovp_trip_h |=> ovp_shutdown ##1 !power_switch_on)
        else $error("overvoltage trip did not shut down");
    ovp_hold_a: assert property ((r_reg.mode == led_boost_pkg::ST_OVP && r_reg.sync2.dim)
        |=> r_reg.mode == led_boost_pkg::ST_OVP [*2])
        else $error("overvoltage latch released while input high");
    low_shutdown_a: assert property ((!r_reg.sync2.dim && r_reg.low_cnt == LOW_LAST)
        |=> r_reg.mode inside {led_boost_pkg::ST_OFF, led_boost_pkg::ST_OVP})
        else $error("long low did not shut down");
    ref_chop_a: assert property ((r_reg.act && r_reg.sync2.dim
        && r_next.act) |=> ref_gate)
        else $error("reference not gated with input");
    full_ref_a: assert property ((ref_gate && lpf_level == led_boost_pkg::REF_FULL_MV)
        |=> lpf_level == led_boost_pkg::REF_FULL_MV)
        else $error("full reference not held");
    lpf_smooth_a: assert property ((lpf_level <= led_boost_pkg::REF_FULL_MV)
        && (lpf_level - $past(lpf_level) <= 8'h01 || $past(lpf_level) - lpf_level <= 8'h01))
        else $error("filtered reference stepped");
    supply_undervoltage_lockout_off_a: assert property (!r_reg.sync2.supply_ok |=> !switching_active
        ##1 !power_switch_on)
        else $error("switch active under lockout");
    thermal_off_a: assert property (r_reg.sync2.hot |=> !switching_active)
        else $error("switch active while hot");
    enable_start_a: assert property ((r_reg.mode == led_boost_pkg::ST_OFF && r_reg.sync2.dim
        && r_reg.sync2.supply_ok && !r_reg.sync2.hot) |=> switching_active)
        else $error("enable did not start soft-start");
    disabled_quiet_a: assert property (!switching_active |-> !power_switch_on
        && low_power && reg_target == '0)
        else $error("switching while disabled");
    soft_ramp_a: assert property (reg_target <= $past(r_reg.soft_level))
        else $error("target above soft-start ceiling");
    ilim_off_a: assert property (r_reg.sync2.ilim |=> !power_switch_on)
        else $error("switch on past current threshold");
    low_restart_a: assert property (r_reg.sync2.dim |=> r_reg.low_cnt == '0)
        else $error("low timer not cleared");

    soft_to_run_c: cover property (r_reg.mode == led_boost_pkg::ST_SOFT
        ##1 r_reg.mode == led_boost_pkg::ST_RUN);
    ovp_trip_c: cover property (ovp_trip_h ##1 ovp_shutdown);
    long_low_c: cover property (r_reg.mode == led_boost_pkg::ST_RUN
        ##1 r_reg.mode == led_boost_pkg::ST_OFF);
endmodule : led_boost_dim_protect_ctrl

// File: sim/pwm_dim_host.sv
// Purpose: host model driving the dimming/enable pin
// Assumes: bench changes the controls just after a rising edge
// Notes: a held level or a free running pulse train, no other shapes
`timescale 1ns/10ps
module pwm_dim_host (
    input wire logic mclk,
    input wire logic pwm_run,
    input wire logic hold_level,
    input wire logic [15:0] period_cyc,
    input wire logic [15:0] high_cyc,
    output logic dim
);
    // ==========================================================
    // pulse train
    // ==========================================================
    logic [15:0] phase_reg = 16'h0000; // position in the period
    logic dim_reg = 1'b0; // pin level, starts low like the pull-down
    assign dim = dim_reg;
    // pin changes on the edge by non-blocking update, never mid-cycle
    always @(posedge mclk) begin
        if (!pwm_run) begin
            // static level, phase parked at zero
            phase_reg <= 16'h0000;
            dim_reg <= hold_level;
        end else begin
            // period bounds: bench picks 1000 to 10000 cycles
            phase_reg <= (phase_reg >= period_cyc - 16'h0001) ? 16'h0000 : phase_reg + 16'h0001;
            // duty floor: high_cyc kept at or above period/500
            dim_reg <= (phase_reg < high_cyc);
        end
    end
endmodule : pwm_dim_host

// File: sim/tb_top.sv
// Purpose: self-checking bench of the boost LED controller
// Assumes: 100 MHz mclk, inputs moved 1 ns after the rising edge
// Notes: low-time shutdown shortened to 1000 cycles, still above the 500-cycle dimming low;
// soft-start steps shortened to 200 cycles so the whole run stays short
`timescale 1ns/10ps
module tb_top;
    // ==========================================================
    // signals
    // ==========================================================
    localparam int LOW_SD = 1000; // shortened low-time count, above a dimming low phase
    localparam int SOFT_STEP = 200; // shortened soft-start step, 200 steps to full
    localparam int SW_PER = 83; // switching period in cycles
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic supply_ok = 1'b0, hot = 1'b0, ovp = 1'b0, ilim = 1'b0;
    logic pwm_run = 1'b0, hold_level = 1'b0, dim;
    logic [15:0] period_cyc = 16'h03E8, high_cyc = 16'h01F4; // 100 kHz, half duty
    led_boost_pkg::sense_t sense_pins;
    logic power_switch_on, switching_active, low_power, ref_gate, ovp_shutdown;
    logic [led_boost_pkg::REF_W-1:0] reg_target, min_target;
    int n_errors = 0, n_compared = 0, cycles = 0, i;
    assign sense_pins = '{dim: dim, supply_ok: supply_ok, hot: hot, ovp: ovp, ilim: ilim};

    led_boost_dim_protect_ctrl #(.LOW_SD_CYC(LOW_SD), .SOFT_STEP_CYC(SOFT_STEP)) dut (
        .mclk(mclk), .reset(reset),
        .sense_pins(sense_pins), .power_switch_on(power_switch_on),
        .switching_active(switching_active), .low_power(low_power), .ref_gate(ref_gate),
        .reg_target(reg_target), .ovp_shutdown(ovp_shutdown));
    pwm_dim_host host (.mclk(mclk), .pwm_run(pwm_run), .hold_level(hold_level),
        .period_cyc(period_cyc), .high_cyc(high_cyc), .dim(dim));

    // ==========================================================
    // clock, timeout and helpers
    // ==========================================================
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ceiling well above the ~75k cycles the scenarios need
    always @(posedge mclk) begin
        cycles++;
        if (cycles >= 90000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // scenarios
    // ==========================================================
    // idle quiet: supply fine but pin low, nothing switches
    task automatic sc_idle();
        check({7'h00, low_power}, 8'h01);
        supply_ok = 1'b1;
        tick(20);
        check({7'h00, switching_active}, 8'h00);
        check({7'h00, power_switch_on}, 8'h00);
        check({7'h00, low_power}, 8'h01);
    endtask : sc_idle
    // start and ramp to full reference
    task automatic sc_soft_start();
        hold_level = 1'b1;
        tick(6);
        check({7'h00, switching_active}, 8'h01);
        check({7'h00, low_power}, 8'h00);
        check({7'h00, ref_gate}, 8'h01);
        tick(2000);
        // ten ramp steps of 200 cycles, the filter is far ahead
        check({7'h00, reg_target >= 8'h08 && reg_target <= 8'h0B}, 8'h01);
        // ramp is full after 40k cycles, the filter settles on 200 within about 48k
        tick(55000);
        check(reg_target, led_boost_pkg::REF_FULL_MV);
    endtask : sc_soft_start
    // switch turned on each period, cut by current limit
    task automatic sc_switch_cycle();
        for (i = 0; i < SW_PER + 5 && power_switch_on !== 1'b1; i++) tick(1);
        check({7'h00, power_switch_on}, 8'h01);
        ilim = 1'b1;
        tick(4);
        check({7'h00, power_switch_on}, 8'h00);
        min_target = 8'h00;
        for (i = 0; i < SW_PER + 10; i++) begin
            tick(1);
            min_target = min_target | {7'h00, power_switch_on};
        end
        check(min_target, 8'h00);
        ilim = 1'b0;
    endtask : sc_switch_cycle
    // half duty: gate follows pin, target falls smoothly
    task automatic sc_dimming();
        pwm_run = 1'b1;
        @(posedge dim);
        tick(10);
        check({7'h00, ref_gate}, 8'h01);
        tick(500);
        check({7'h00, ref_gate}, 8'h00);
        min_target = 8'hFF;
        for (i = 0; i < 9000; i++) begin
            tick(1);
            if (reg_target < min_target) min_target = reg_target;
        end
        // a pulsed target would drop to zero in every low phase
        check({7'h00, min_target >= 8'h64}, 8'h01);
        check({7'h00, reg_target <= 8'hB4}, 8'h01);
        pwm_run = 1'b0;
    endtask : sc_dimming
    // short lows are harmless, a long low shuts down
    task automatic sc_long_low();
        repeat (5) begin
            hold_level = 1'b0;
            tick(LOW_SD - 50);
            hold_level = 1'b1;
            tick(20);
        end
        check({7'h00, switching_active}, 8'h01);
        hold_level = 1'b0;
        tick(LOW_SD - 10);
        check({7'h00, switching_active}, 8'h01);
        tick(20);
        check({7'h00, switching_active}, 8'h00);
        check({7'h00, low_power}, 8'h01);
        check({7'h00, power_switch_on}, 8'h00);
    endtask : sc_long_low
    // lockout and heat stop, then automatic restart
    task automatic sc_supply_heat();
        supply_ok = 1'b0;
        hold_level = 1'b1;
        tick(20);
        check({7'h00, switching_active}, 8'h00);
        supply_ok = 1'b1;
        tick(6);
        check({7'h00, switching_active}, 8'h01);
        hot = 1'b1;
        tick(6);
        check({7'h00, switching_active}, 8'h00);
        check({7'h00, power_switch_on}, 8'h00);
        hot = 1'b0;
        tick(6);
        check({7'h00, switching_active}, 8'h01);
    endtask : sc_supply_heat
    // eight overvoltage periods latch, long low releases
    task automatic sc_overvoltage();
        ovp = 1'b1;
        // seven full periods less ten cycles cannot yet reach eight
        tick(7 * SW_PER - 10);
        check({7'h00, ovp_shutdown}, 8'h00);
        for (i = 0; i < 200 && ovp_shutdown !== 1'b1; i++) tick(1);
        check({7'h00, ovp_shutdown}, 8'h01);
        check({7'h00, switching_active | power_switch_on}, 8'h00);
        ovp = 1'b0;
        hold_level = 1'b0;
        tick(50);
        hold_level = 1'b1;
        tick(20);
        check({7'h00, ovp_shutdown}, 8'h01);
        hold_level = 1'b0;
        tick(LOW_SD + 20);
        hold_level = 1'b1;
        tick(10);
        check({7'h00, ovp_shutdown}, 8'h00);
        check({7'h00, switching_active}, 8'h01);
    endtask : sc_overvoltage

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        tick(5);
        reset = 1'b0;
        sc_idle();
        sc_soft_start();
        sc_switch_cycle();
        sc_dimming();
        sc_long_low();
        sc_supply_heat();
        sc_overvoltage();
        wrap_up();
    end
endmodule : tb_top
